// file: logic/rlc_classify.sv
// Purpose: Combinational screening of one inbound packet descriptor.
// Assumes: Descriptor fields are valid whenever pkt_valid is high.
// Notes:   Only the first matching fault is reported for a packet.

`timescale 1ns/1ns

// =====================================================================
// Classifier
// =====================================================================
module rlc_classify (
   input  wire logic                  pkt_valid,
   input  wire rlc_pkg::rlc_pkt_t     pkt,
   output logic [31:0]                err_vec,
   output logic                       pw_req,
   output logic                       cc_req,
   output logic                       silent,
   output rlc_pkg::rlc_verdict_t      verdict
);
   import rlc_pkg::*;

   logic admit_w;
   logic odd_pay_w;
   logic wr_op_w;
   logic posted_w;

   // Packets failing transport checks never reach the logger.
   assign admit_w   = pkt.tt_ok && pkt.id_match && pkt.ftype_ok && pkt.unit_en;
   assign odd_pay_w = (pkt.pay_bytes[2:0] & RLC_DW_MASK) != 3'h0;
   assign wr_op_w   = (pkt.op == RLC_OP_NWRITE) || (pkt.op == RLC_OP_NWRITE_R)
                      || (pkt.op == RLC_OP_SWRITE);
   assign posted_w  = (pkt.op == RLC_OP_NWRITE) || (pkt.op == RLC_OP_SWRITE);
   assign silent    = pkt_valid && !admit_w;

   // Priority decision per packet class.
   always_comb begin
      err_vec = 32'h0000_0000;
      pw_req  = 1'b0;
      cc_req  = 1'b0;
      verdict = '{accept: 1'b0, discard: 1'b0, err_resp: 1'b0, retry: 1'b0};
      if (pkt_valid && !admit_w) begin
         verdict.discard = 1'b1;
      end else if (pkt_valid) begin
         unique case (pkt.kind)
            RLC_KIND_REQ: begin
               // Address is always double-word aligned, so no alignment check.
               if (pkt.unsupported) begin
                  err_vec[RLC_BIT_UNSUP] = 1'b1;
               end else if (wr_op_w && odd_pay_w) begin
                  err_vec[RLC_BIT_FORMAT] = 1'b1;
               end
               if (err_vec != 32'h0000_0000) begin
                  pw_req           = 1'b1;
                  verdict.discard  = 1'b1;
                  verdict.err_resp = !posted_w;
               end else begin
                  verdict.accept = 1'b1;
               end
            end
            RLC_KIND_RESP: begin
               pw_req = 1'b1;
               if (!pkt.solicited) begin
                  err_vec[RLC_BIT_UNSOL] = 1'b1;
               end else if (pkt.status_err && pkt.pay_bytes != '0) begin
                  err_vec[RLC_BIT_FORMAT] = 1'b1;
                  pw_req = 1'b0;
                  cc_req = 1'b1;
               end else if (pkt.status_err) begin
                  err_vec[RLC_BIT_ERR_STATUS] = 1'b1;
                  cc_req = 1'b1;
               end else if (pkt.rsvd_enc) begin
                  err_vec[RLC_BIT_FORMAT] = 1'b1;
                  pw_req = 1'b0;
                  cc_req = 1'b1;
               end else if (pkt.op == RLC_OP_READ
                            && (pkt.pay_bytes == '0 || pkt.pay_bytes != pkt.size_bytes)) begin
                  err_vec[RLC_BIT_FORMAT] = 1'b1;
                  cc_req = 1'b1;
               end else if (pkt.op == RLC_OP_READ && odd_pay_w) begin
                  err_vec[RLC_BIT_FORMAT] = 1'b1;
                  pw_req = 1'b0;
               end else if (pkt.op != RLC_OP_READ && pkt.op != RLC_OP_TAS
                            && pkt.pay_bytes != '0) begin
                  // Own write requests never overrun their size, so no size check.
                  err_vec[RLC_BIT_FORMAT] = 1'b1;
                  cc_req = 1'b1;
               end
               if (err_vec != 32'h0000_0000) begin
                  verdict.discard = 1'b1;
               end else begin
                  pw_req = 1'b0;
                  verdict.accept = 1'b1;
               end
            end
            RLC_KIND_MSG: begin
               // Segments past sixteen open the next message, so no count check.
               if (pkt.queue_busy) begin
                  verdict.retry = 1'b1;
               end else if (pkt.pay_bytes == '0) begin
                  err_vec[RLC_BIT_MSG_SIZE] = 1'b1;
               end else if (odd_pay_w) begin
                  err_vec[RLC_BIT_MSG_SIZE] = 1'b1;
               end else if (pkt.msgseg > pkt.msglen) begin
                  err_vec[RLC_BIT_FORMAT] = 1'b1;
               end
               if (err_vec != 32'h0000_0000) begin
                  pw_req           = 1'b1;
                  verdict.discard  = 1'b1;
                  verdict.err_resp = 1'b1;
               end else if (!pkt.queue_busy) begin
                  verdict.accept = 1'b1;
               end
            end
            default: begin
               verdict.discard = 1'b1;
            end
         endcase
      end
   end

endmodule // rlc_classify

// file: logic/rlc_error_checker.sv
// Purpose: Logical-layer error checker and logger with an APB register file.
// Assumes: Packet and timeout inputs come from logic on pclk; no synchronising.
// Notes:   Zero-wait APB slave; verdicts and codes appear one cycle after input.
//
// Summary of operation
// - No error response for faulty NWRITE or SWRITE.
// - Unsupported request: respond, drop, bit 22, log.
// - Address field is upper 29 bits, always aligned.
// - Write payload not 8-byte multiple: bit 27.
// - Unsolicited response: silent drop, bit 23, log.
// - Read response size wrong or empty: bit 27, code 011.
// - Read response not 8-byte multiple: drop, bit 27.
// - Write response with payload: bit 27, except test-and-swap.
// - Response timeout: bit 24, log, code 001.
// - ERROR status response: drop, bit 31, code 011.
// - ERROR response with payload: bit 27, code 011.
// - Reserved encoding in response: bit 27, code 011.
// - Own writes never overrun size, no check.
// - Empty message: drop, respond, bit 28, log.
// - Message payload not 8-byte multiple: bit 28.
// - Extra segments start next message, not error.
// - Busy receive queue answers message with RETRY.
// - Segment index above length: drop, bit 27, log.
// - Capture high address, address, identifiers, control.
// - Enabled port-writes go to programmed target identifier.
// - Each error needs its enable bit to port-write.
// - Transport-level failures dropped silently, never logged.

`timescale 1ns/1ns

// =====================================================================
// Top module
// =====================================================================
module rlc_error_checker (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic                  pkt_valid_i,
   input  wire rlc_pkg::rlc_pkt_t     pkt_i,
   input  wire logic                  to_valid_i,
   input  wire rlc_pkg::rlc_pkt_t     to_pkt_i,
   output logic                       verdict_valid_o,
   output rlc_pkg::rlc_verdict_t      verdict_o,
   output logic                       cc_valid_o,
   output logic [2:0]                 cc_o,
   output logic                       pw_valid_o,
   input  wire logic                  pw_ready_i,
   output logic [15:0]                pw_tgt_id_o,
   output logic [31:0]                pw_err_det_o
);
   import rlc_pkg::*;

   // =================================================================
   // Packet screening
   // =================================================================
   logic [31:0]  cls_err_vec;
   logic         cls_pw;
   logic         cls_cc;
   logic         cls_silent;
   rlc_verdict_t cls_verdict;

   rlc_classify u_classify (
      .pkt_valid (pkt_valid_i),
      .pkt       (pkt_i),
      .err_vec   (cls_err_vec),
      .pw_req    (cls_pw),
      .cc_req    (cls_cc),
      .silent    (cls_silent),
      .verdict   (cls_verdict)
   );

   // =================================================================
   // Register state
   // =================================================================
   logic         pw_en_q;
   logic [31:0]  err_det_q;
   logic [31:0]  err_det_d;
   logic [31:0]  err_en_q;
   logic [31:0]  pw_tgt_q;
   logic [31:0]  cap_haddr_q;
   logic [31:0]  cap_addr_q;
   logic [31:0]  cap_devid_q;
   logic [31:0]  cap_ctrl_q;
   logic         verdict_valid_q;
   rlc_verdict_t verdict_q;
   logic         cc_valid_q;
   logic [2:0]   cc_q;
   logic         pw_pending_q;
   logic [31:0]  pw_err_det_q;

   // =================================================================
   // APB decode
   // =================================================================
   logic        acc_w;
   logic        wr_w;
   logic        hit_w;
   logic        wr_ctl_w;
   logic        wr_det_w;
   logic        wr_en_w;
   logic        wr_tgt_w;
   logic [31:0] det_clear_w;

   // Zero-wait slave; unmapped offsets answer with an error and read zero.
   assign acc_w    = psel && penable;
   assign wr_w     = acc_w && pwrite;
   assign hit_w    = (paddr == RLC_OFS_PW_CTL)    || (paddr == RLC_OFS_ERR_DET)
                     || (paddr == RLC_OFS_ERR_EN)  || (paddr == RLC_OFS_CAP_HADDR)
                     || (paddr == RLC_OFS_CAP_ADDR) || (paddr == RLC_OFS_CAP_DEVID)
                     || (paddr == RLC_OFS_CAP_CTRL) || (paddr == RLC_OFS_PW_TGT);
   assign wr_ctl_w = wr_w && (paddr == RLC_OFS_PW_CTL);
   assign wr_det_w = wr_w && (paddr == RLC_OFS_ERR_DET);
   assign wr_en_w  = wr_w && (paddr == RLC_OFS_ERR_EN);
   assign wr_tgt_w = wr_w && (paddr == RLC_OFS_PW_TGT);
   assign det_clear_w = wr_det_w ? pwdata : 32'h0000_0000;
   assign pready   = 1'b1;
   assign pslverr  = acc_w && !hit_w;

   // Read mux over the register flops.
   always_comb begin
      prdata = 32'h0000_0000;
      unique case (paddr)
         RLC_OFS_PW_CTL:    prdata[RLC_BIT_PW_EN] = pw_en_q;
         RLC_OFS_ERR_DET:   prdata = err_det_q;
         RLC_OFS_ERR_EN:    prdata = err_en_q;
         RLC_OFS_CAP_HADDR: prdata = cap_haddr_q;
         RLC_OFS_CAP_ADDR:  prdata = cap_addr_q;
         RLC_OFS_CAP_DEVID: prdata = cap_devid_q;
         RLC_OFS_CAP_CTRL:  prdata = cap_ctrl_q;
         RLC_OFS_PW_TGT:    prdata = pw_tgt_q;
         default:           prdata = 32'h0000_0000;
      endcase
   end

   // =================================================================
   // Error logging
   // =================================================================
   logic [31:0] to_vec_w;
   logic [31:0] set_vec_w;
   logic [31:0] pw_src_w;
   logic        log_pkt_w;
   logic        cap_load_w;
   logic        pw_trig_w;
   logic        pw_mask_hit_w;
   rlc_pkt_t    cap_src_w;

   // A timeout marks its own bit; a packet fault in the same cycle is captured first.
   assign to_vec_w   = to_valid_i ? (32'h0000_0001 << RLC_BIT_TIMEOUT) : 32'h0000_0000;
   assign set_vec_w  = cls_err_vec | to_vec_w;
   assign log_pkt_w  = cls_err_vec != 32'h0000_0000;
   assign cap_src_w  = log_pkt_w ? pkt_i : to_pkt_i;
   // Captures only load while nothing is logged, so the first fault survives.
   assign cap_load_w = (set_vec_w != 32'h0000_0000) && (err_det_q == 32'h0000_0000);
   // Set wins over the write-one-to-clear in the same cycle.
   assign err_det_d  = (err_det_q & ~det_clear_w) | set_vec_w;
   assign pw_src_w   = (cls_pw ? cls_err_vec : 32'h0000_0000) | to_vec_w;
   assign pw_mask_hit_w = (pw_src_w & err_en_q) != 32'h0000_0000;
   assign pw_trig_w  = pw_en_q && pw_mask_hit_w;

   // Control registers written by software.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pw_en_q  <= RLC_RST_PW_EN;
         err_en_q <= RLC_RST_ERR_EN;
         pw_tgt_q <= RLC_RST_PW_TGT;
      end else begin
         if (wr_ctl_w) pw_en_q <= pwdata[RLC_BIT_PW_EN];
         if (wr_en_w) err_en_q <= pwdata;
         if (wr_tgt_w) pw_tgt_q <= pwdata;
      end
   end

   // Sticky detect bits and the four capture words.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_det_q   <= RLC_RST_ERR_DET;
         cap_haddr_q <= RLC_RST_CAP;
         cap_addr_q  <= RLC_RST_CAP;
         cap_devid_q <= RLC_RST_CAP;
         cap_ctrl_q  <= RLC_RST_CAP;
      end else begin
         err_det_q <= err_det_d;
         if (cap_load_w) begin
            cap_haddr_q <= cap_src_w.haddr;
            cap_addr_q  <= {cap_src_w.addr, 3'b000};
            cap_devid_q <= {cap_src_w.dst_id, cap_src_w.src_id};
            cap_ctrl_q  <= {cap_src_w.ftype, cap_src_w.ttype, cap_src_w.msgseg,
                            cap_src_w.msglen, 5'h00, cap_src_w.op, 6'h00,
                            cap_src_w.kind};
         end
      end
   end

   // =================================================================
   // Verdict and completion code
   // =================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         verdict_valid_q <= 1'b0;
         verdict_q       <= '{accept: 1'b0, discard: 1'b0, err_resp: 1'b0, retry: 1'b0};
         cc_valid_q      <= 1'b0;
         cc_q            <= 3'h0;
      end else begin
         verdict_valid_q <= pkt_valid_i;
         verdict_q       <= cls_verdict;
         // A packet fault is reported ahead of a coincident timeout.
         cc_valid_q      <= cls_cc || to_valid_i;
         if (cls_cc) begin
            cc_q <= RLC_CC_ERROR;
         end else if (to_valid_i) begin
            cc_q <= RLC_CC_TIMEOUT;
         end
      end
   end

   assign verdict_valid_o = verdict_valid_q;
   assign verdict_o       = verdict_q;
   assign cc_valid_o      = cc_valid_q;
   assign cc_o            = cc_q;

   // =================================================================
   // Port-write request
   // =================================================================
   // Triggers while one is pending are dropped; the snapshot keeps the first.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pw_pending_q <= 1'b0;
         pw_err_det_q <= RLC_RST_ERR_DET;
      end else begin
         if (pw_pending_q && pw_ready_i) begin
            pw_pending_q <= 1'b0;
         end else if (pw_trig_w && !pw_pending_q) begin
            pw_pending_q <= 1'b1;
            pw_err_det_q <= err_det_d;
         end
      end
   end

   assign pw_valid_o   = pw_pending_q;
   assign pw_tgt_id_o  = pw_tgt_q[15:0];
   assign pw_err_det_o = pw_err_det_q;

   // =================================================================
   // Checks
   // =================================================================
   logic admit_w;
   assign admit_w = pkt_valid_i && !cls_silent;

   chk_posted_no_resp: assert property (@(posedge pclk) disable iff (!presetn)
      admit_w && pkt_i.kind == RLC_KIND_REQ
      && (pkt_i.op == RLC_OP_NWRITE || pkt_i.op == RLC_OP_SWRITE)
      |=> verdict_valid_o && !verdict_o.err_resp)
      else $error("posted write got an error response");

   chk_unsup_logged: assert property (@(posedge pclk) disable iff (!presetn)
      admit_w && pkt_i.kind == RLC_KIND_REQ && pkt_i.unsupported
      && pkt_i.op == RLC_OP_OTHER
      |=> err_det_q[RLC_BIT_UNSUP] && verdict_o.discard && verdict_o.err_resp)
      else $error("unsupported request not handled");

   chk_unsol_silent: assert property (@(posedge pclk) disable iff (!presetn)
      admit_w && pkt_i.kind == RLC_KIND_RESP && !pkt_i.solicited
      |=> err_det_q[RLC_BIT_UNSOL] && verdict_o.discard && !verdict_o.err_resp)
      else $error("unsolicited response mishandled");

   chk_timeout_code: assert property (@(posedge pclk) disable iff (!presetn)
      to_valid_i && !cls_cc
      |=> cc_valid_o && cc_o == 3'h1 && err_det_q[RLC_BIT_TIMEOUT])
      else $error("timeout did not report code 001");

   chk_status_error: assert property (@(posedge pclk) disable iff (!presetn)
      admit_w && pkt_i.kind == RLC_KIND_RESP && pkt_i.solicited
      && pkt_i.status_err && pkt_i.pay_bytes == '0
      |=> err_det_q[RLC_BIT_ERR_STATUS] && cc_valid_o && cc_o == 3'h3)
      else $error("error status response mishandled");

   chk_msg_retry: assert property (@(posedge pclk) disable iff (!presetn)
      admit_w && pkt_i.kind == RLC_KIND_MSG && pkt_i.queue_busy
      |=> verdict_o.retry && !verdict_o.accept && !verdict_o.discard)
      else $error("busy queue did not retry");

   chk_msg_segment: assert property (@(posedge pclk) disable iff (!presetn)
      admit_w && pkt_i.kind == RLC_KIND_MSG && !pkt_i.queue_busy
      && pkt_i.pay_bytes == 9'h008 && pkt_i.msgseg > pkt_i.msglen
      |=> err_det_q[RLC_BIT_FORMAT] && verdict_o.err_resp)
      else $error("segment beyond length not rejected");

   chk_silent_drop: assert property (@(posedge pclk) disable iff (!presetn)
      cls_silent && !to_valid_i && !wr_det_w
      |=> verdict_o.discard && $stable(err_det_q) && !verdict_o.err_resp)
      else $error("transport failure was logged");

   chk_capture_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (err_det_q != 32'h0000_0000) && !wr_det_w
      |=> $stable(cap_haddr_q) && $stable(cap_devid_q) && (err_det_q != 32'h0000_0000))
      else $error("capture overwritten while logged");

   chk_pw_masked: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(pw_valid_o) |-> $past(pw_en_q) && $past(pw_mask_hit_w))
      else $error("port-write without enable");

   chk_pw_hold: assert property (@(posedge pclk) disable iff (!presetn)
      pw_valid_o && !pw_ready_i |=> pw_valid_o)
      else $error("port-write dropped before acceptance");

   chk_msg_empty: assert property (@(posedge pclk) disable iff (!presetn)
      admit_w && pkt_i.kind == RLC_KIND_MSG && !pkt_i.queue_busy && pkt_i.pay_bytes == '0
      |=> err_det_q[RLC_BIT_MSG_SIZE] && verdict_o.err_resp)
      else $error("empty message not rejected");

endmodule // rlc_error_checker

// file: shared/rlc_pkg.sv
// Purpose: Shared constants and types for the logical-layer error checker.
// Assumes: Register offsets are byte addresses on a 32-bit APB.
// Notes:   Every offset, bit position, reset value and code is named here once.

// =====================================================================
// Package
// =====================================================================
package rlc_pkg;

   // Register byte offsets.
   localparam logic [11:0] RLC_OFS_PW_CTL    = 12'h000;
   localparam logic [11:0] RLC_OFS_ERR_DET   = 12'h008;
   localparam logic [11:0] RLC_OFS_ERR_EN    = 12'h00C;
   localparam logic [11:0] RLC_OFS_CAP_HADDR = 12'h010;
   localparam logic [11:0] RLC_OFS_CAP_ADDR  = 12'h014;
   localparam logic [11:0] RLC_OFS_CAP_DEVID = 12'h018;
   localparam logic [11:0] RLC_OFS_CAP_CTRL  = 12'h01C;
   localparam logic [11:0] RLC_OFS_PW_TGT    = 12'h028;

   // Error-detect bit positions.
   localparam int RLC_BIT_ERR_STATUS = 31;
   localparam int RLC_BIT_MSG_SIZE   = 28;
   localparam int RLC_BIT_FORMAT     = 27;
   localparam int RLC_BIT_TIMEOUT    = 24;
   localparam int RLC_BIT_UNSOL      = 23;
   localparam int RLC_BIT_UNSUP      = 22;

   // Port-write control field position.
   localparam int RLC_BIT_PW_EN = 0;

   // Reset values.
   localparam logic [31:0] RLC_RST_ERR_DET = 32'h0000_0000;
   localparam logic [31:0] RLC_RST_ERR_EN  = 32'h0000_0000;
   localparam logic [31:0] RLC_RST_PW_TGT  = 32'h0000_0000;
   localparam logic [31:0] RLC_RST_CAP     = 32'h0000_0000;
   localparam logic        RLC_RST_PW_EN   = 1'b0;

   // Completion codes reported to the direct-I/O initiator.
   localparam logic [2:0] RLC_CC_TIMEOUT = 3'h1;
   localparam logic [2:0] RLC_CC_ERROR   = 3'h3;

   // Payload sizing: bytes field width and double-word alignment mask.
   localparam int         RLC_PAY_W   = 9;
   localparam logic [2:0] RLC_DW_MASK = 3'h7;

   typedef enum logic [1:0] {
      RLC_KIND_REQ,
      RLC_KIND_RESP,
      RLC_KIND_MSG
   } rlc_kind_t;

   typedef enum logic [2:0] {
      RLC_OP_READ,
      RLC_OP_NWRITE,
      RLC_OP_NWRITE_R,
      RLC_OP_SWRITE,
      RLC_OP_TAS,
      RLC_OP_OTHER
   } rlc_op_t;

   // Inbound packet descriptor; for a response, op is that of the matched request.
   typedef struct packed {
      rlc_kind_t              kind;
      rlc_op_t                op;
      logic [3:0]             ftype;
      logic [3:0]             ttype;
      logic [31:0]            haddr;
      logic [28:0]            addr;
      logic [15:0]            src_id;
      logic [15:0]            dst_id;
      logic [RLC_PAY_W-1:0]   size_bytes;
      logic [RLC_PAY_W-1:0]   pay_bytes;
      logic                   status_err;
      logic                   rsvd_enc;
      logic                   unsupported;
      logic                   solicited;
      logic                   tt_ok;
      logic                   id_match;
      logic                   ftype_ok;
      logic                   unit_en;
      logic                   queue_busy;
      logic [3:0]             msgseg;
      logic [3:0]             msglen;
   } rlc_pkt_t;

   typedef struct packed {
      logic accept;
      logic discard;
      logic err_resp;
      logic retry;
   } rlc_verdict_t;

endpackage

// file: verif/rlc_error_checker_tb.sv
// Purpose: Self-checking bench for the logical-layer error checker.
// Assumes: Zero-wait APB slave; verdicts one cycle after a packet.
// Notes:   Detect bits are cleared after each case but the final port-write ones, so that each stands alone.
`timescale 1ns/1ns
// =====================================================================
// Bench
module rlc_error_checker_tb;
   import rlc_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tov = 0, err;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, rd, prdata, det;
   logic pready, pslverr, vv, cv, pwv, pwr, pv;
   logic [2:0] cc;
   logic [15:0] tgt;
   rlc_verdict_t vo;
   rlc_pkt_t pk, p, tp = '0;
   int n_mismatch = 0, checks = 0;
   // Clock at 25 MHz.
   always #20 pclk = ~pclk;
   rlc_error_checker dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .pkt_valid_i(pv), .pkt_i(pk), .to_valid_i(tov),
      .to_pkt_i(tp), .verdict_valid_o(vv), .verdict_o(vo), .cc_valid_o(cv), .cc_o(cc),
      .pw_valid_o(pwv), .pw_ready_i(pwr), .pw_tgt_id_o(tgt), .pw_err_det_o(det));
   rlc_remote_ep ep (.pclk, .pw_valid(pwv), .pw_ready(pwr), .pkt_valid(pv), .pkt(pk));
   // Compare and count; a mismatch is printed at once.
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("FAIL t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic print_verdict;
      if (n_mismatch == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // APB transfer; request held until pready is seen high.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
      // Let one edge pass before any next setup.
      @(posedge pclk);
   endtask
   function automatic rlc_pkt_t mk(rlc_kind_t k, rlc_op_t o, int n);
      mk = '0;
      {mk.tt_ok, mk.id_match, mk.ftype_ok, mk.unit_en, mk.solicited} = '1;
      {mk.kind, mk.op, mk.pay_bytes, mk.size_bytes} = {k, o, n[8:0], 9'h008};
      {mk.src_id, mk.dst_id, mk.addr, mk.msglen} = {16'h0012, 16'h0034, 29'h0123_4567, 4'h3};
   endfunction
   // One packet: verdict, then detect bits, then clear them.
   task automatic ex(input rlc_pkt_t q, input logic [3:0] v, input int b);
      ep.send(q);
      @(posedge pclk);
      chk(vv, 1);
      chk(vo, v);
      apb(0, RLC_OFS_ERR_DET, '0);
      chk(rd, (b < 0) ? 32'h0 : 32'h1 << b);
      apb(1, RLC_OFS_ERR_DET, '1);
   endtask
   // Watchdog, far beyond the expected run of a few hundred cycles.
   initial begin
      #400000;
      n_mismatch++;
      print_verdict();
   end
   // Main sequence.
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, RLC_OFS_ERR_DET, '0);
      chk(rd, RLC_RST_ERR_DET);
      apb(1, RLC_OFS_PW_CTL, 32'h0000_0001);
      apb(1, RLC_OFS_ERR_EN, 32'hFFFF_FFFF);
      apb(1, RLC_OFS_PW_TGT, 32'h0000_00A5);
      chk(tgt, 32'h0000_00A5);
      p = mk(RLC_KIND_REQ, RLC_OP_OTHER, 8);
      p.unsupported = 1'b1;
      ex(p, 4'b0110, RLC_BIT_UNSUP);
      apb(0, RLC_OFS_CAP_DEVID, '0);
      chk(rd, 32'h0034_0012);
      apb(0, RLC_OFS_CAP_ADDR, '0);
      chk(rd, 32'h091A_2B38);
      ex(mk(RLC_KIND_REQ, RLC_OP_NWRITE, 12), 4'b0100, RLC_BIT_FORMAT);
      ex(mk(RLC_KIND_REQ, RLC_OP_NWRITE_R, 12), 4'b0110, RLC_BIT_FORMAT);
      ex(mk(RLC_KIND_RESP, RLC_OP_READ, 0), 4'b0100, RLC_BIT_FORMAT);
      chk(cc, RLC_CC_ERROR);
      ex(mk(RLC_KIND_RESP, RLC_OP_READ, 8), 4'b1000, -1);
      p = mk(RLC_KIND_RESP, RLC_OP_READ, 12);
      p.size_bytes = 9'h00C;
      ex(p, 4'b0100, RLC_BIT_FORMAT);
      ex(mk(RLC_KIND_RESP, RLC_OP_NWRITE_R, 8), 4'b0100, RLC_BIT_FORMAT);
      ex(mk(RLC_KIND_RESP, RLC_OP_TAS, 8), 4'b1000, -1);
      tp <= mk(RLC_KIND_REQ, RLC_OP_READ, 8);
      tov <= 1'b1;
      @(posedge pclk);
      tov <= 1'b0;
      @(posedge pclk);
      chk({cv, cc}, {1'b1, RLC_CC_TIMEOUT});
      apb(0, RLC_OFS_ERR_DET, '0);
      chk(rd, 32'h0100_0000);
      apb(1, RLC_OFS_ERR_DET, '1);
      p = mk(RLC_KIND_RESP, RLC_OP_READ, 8);
      p.solicited = 1'b0;
      ex(p, 4'b0100, RLC_BIT_UNSOL);
      p = mk(RLC_KIND_RESP, RLC_OP_READ, 0);
      p.status_err = 1'b1;
      ex(p, 4'b0100, RLC_BIT_ERR_STATUS);
      chk(cc, RLC_CC_ERROR);
      p.pay_bytes = 9'h008;
      ex(p, 4'b0100, RLC_BIT_FORMAT);
      p = mk(RLC_KIND_RESP, RLC_OP_READ, 8);
      p.rsvd_enc = 1'b1;
      ex(p, 4'b0100, RLC_BIT_FORMAT);
      ex(mk(RLC_KIND_MSG, RLC_OP_OTHER, 0), 4'b0110, RLC_BIT_MSG_SIZE);
      ex(mk(RLC_KIND_MSG, RLC_OP_OTHER, 12), 4'b0110, RLC_BIT_MSG_SIZE);
      p = mk(RLC_KIND_MSG, RLC_OP_OTHER, 8);
      p.msgseg = 4'h5;
      ex(p, 4'b0110, RLC_BIT_FORMAT);
      p.queue_busy = 1'b1;
      ex(p, 4'b0001, -1);
      p = mk(RLC_KIND_REQ, RLC_OP_OTHER, 8);
      p.unsupported = 1'b1;
      p.tt_ok = 1'b0;
      ex(p, 4'b0100, -1);
      // Two faults uncleared: bits accumulate, first capture held.
      p.tt_ok = 1'b1;
      ep.send(p);
      @(posedge pclk);
      p = mk(RLC_KIND_RESP, RLC_OP_READ, 8);
      p.solicited = 1'b0;
      p.src_id = 16'h0077;
      ep.send(p);
      apb(0, RLC_OFS_ERR_DET, '0);
      chk(rd, 32'h00C0_0000);
      apb(0, RLC_OFS_CAP_DEVID, '0);
      chk(rd, 32'h0034_0012);
      apb(1, RLC_OFS_ERR_DET, '1);
      apb(1, RLC_OFS_ERR_EN, '0);
      ep.send(p);
      repeat (3) @(posedge pclk);
      chk(pwv, 0);
      apb(1, RLC_OFS_ERR_EN, 32'h0080_0000);
      ep.send(p);
      @(posedge pclk);
      chk(pwv, 1);
      chk(det, 32'h0080_0000);
      apb(0, 12'h0FC, '0);
      chk(err, 1);
      chk(rd, 32'h0);
      print_verdict();
   end
endmodule // rlc_error_checker_tb

// file: verif/rlc_remote_ep.sv
// Purpose: Remote endpoint model that sends packets and takes port-writes.
// Assumes: The bench calls send just after a rising edge.
// Notes:   Takes a port-write one cycle late, so a request stays pending.
`timescale 1ns/1ns
// =====================================================================
// Remote endpoint
module rlc_remote_ep (
   input  wire logic         pclk,
   input  wire logic         pw_valid,
   output logic              pw_ready,
   output logic              pkt_valid,
   output rlc_pkg::rlc_pkt_t pkt
);
   import rlc_pkg::*;
   // An idle descriptor carries the inverse, so stale data cannot pass.
   task automatic send(input rlc_pkt_t p);
      pkt       <= p;
      pkt_valid <= 1'b1;
      @(posedge pclk);
      pkt_valid <= 1'b0;
      pkt       <= ~p;
   endtask
   // Slow acceptor: answers only every other cycle.
   always @(posedge pclk) pw_ready <= pw_valid & ~pw_ready;
   initial pkt_valid = 1'b0;
endmodule // rlc_remote_ep
